// [core/framer_pkg.sv]
// framer_pkg: register map, fields, reset values, symbol codes, timing
// assumes a single 250 MHz system clock.
package framer_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BURST_LEN = 8'h30;
  localparam logic [7:0] ADDR_WAIT_CTRL = 8'h31;
  localparam logic [7:0] ADDR_WAIT_LOW = 8'h32;
  localparam logic [7:0] ADDR_FRAME_CTRL = 8'h33;
  localparam logic [7:0] ADDR_SOF_DETECT = 8'h34;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h35;

  // reset values
  localparam logic [7:0] BURST_LEN_RESET = 8'h00;
  localparam logic [7:0] WAIT_CTRL_RESET = 8'hc0;
  localparam logic [7:0] WAIT_LOW_RESET = 8'h00;
  localparam logic [7:0] FRAME_CTRL_RESET = 8'h00;
  localparam logic [7:0] SOF_DETECT_RESET = 8'h00;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;

  // writable bit masks, the rest reads zero except status bits 4, 1 and 0 of the sof detect register
  localparam logic [7:0] BURST_LEN_WMASK = 8'h70;
  localparam logic [7:0] WAIT_CTRL_WMASK = 8'hff;
  localparam logic [7:0] WAIT_LOW_WMASK = 8'hff;
  localparam logic [7:0] FRAME_CTRL_WMASK = 8'hcf;
  localparam logic [7:0] SOF_DETECT_WMASK = 8'h24;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hcf;

  // field positions
  localparam int BURST_LEN_MSB = 6;
  localparam int BURST_LEN_LSB = 4;
  localparam int WAIT_START_BIT = 7;
  localparam int WAIT_UNIT_BIT = 6;
  localparam int WAIT_HIGH_MSB = 5;
  localparam int WAIT_HIGH_LSB = 3;
  localparam int STOP_LEN_MSB = 2;
  localparam int STOP_LEN_LSB = 0;
  localparam int TX_PARITY_BIT = 7;
  localparam int RX_PARITY_BIT = 6;
  localparam int TRAIL_SYM_MSB = 3;
  localparam int TRAIL_SYM_LSB = 2;
  localparam int LEAD_SYM_MSB = 1;
  localparam int LEAD_SYM_LSB = 0;
  localparam int SOF_IRQ_EN_BIT = 5;
  localparam int SOF_FLAG_BIT = 4;
  localparam int SUBC_IRQ_EN_BIT = 2;
  localparam int SUBC_FLAG_BIT = 1;
  localparam int SUBC_LIVE_BIT = 0;
  localparam int ALLOW_BITS_BIT = 7;
  localparam int MULTI_RX_BIT = 6;
  localparam int DISTURB_BIT = 3;
  localparam int BAUD_MSB = 2;
  localparam int BAUD_LSB = 0;
  localparam logic [2:0] BAUD_26K = 3'h2;
  localparam logic [2:0] BAUD_52K = 3'h3;

  // symbol select codes and driven symbol kinds
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_SYM0 = 2'h1;
  localparam logic [1:0] SEL_SYM1 = 2'h2;
  localparam logic [1:0] SEL_SYM2 = 2'h3;
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_SYM0 = 2'h1;
  localparam logic [1:0] KIND_SYM1 = 2'h2;
  localparam logic [1:0] KIND_SYM2 = 2'h3;

  // carrier wait unit in system clock cycles
  localparam int CLK_KHZ = 250000;
  localparam int CARRIER_KHZ = 13560;
  localparam int CARRIER_PERIODS = 16;
  localparam int WAIT_UNIT_INT = (CARRIER_PERIODS * CLK_KHZ) / CARRIER_KHZ;
  localparam logic [8:0] WAIT_UNIT_CYCLES = WAIT_UNIT_INT[8:0];

  // symbol-one burst length in bits for each length code
  function automatic logic [7:0] burst_bits(input logic [2:0] code);
    case (code)
      3'h0: burst_bits = 8'h08;
      3'h1: burst_bits = 8'h10;
      3'h2: burst_bits = 8'h20;
      3'h3: burst_bits = 8'h20;
      3'h4: burst_bits = 8'h30;
      3'h5: burst_bits = 8'h40;
      3'h6: burst_bits = 8'h60;
      default: burst_bits = 8'h80;
    endcase
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LEAD = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_TRAIL = 3'b100,
    ST_STOP = 3'b101,
    ST_GUARD = 3'b110,
    ST_DONE = 3'b111
  } tx_state_type;

endpackage

// [core/word_buffer.sv]
// word_buffer: two-entry buffer with valid/ready on both sides.
// assumes both sides run on clk
`timescale 1ns/10ps
`default_nettype none
module word_buffer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [8:0] in_data,
  output logic in_ready_q,
  output logic out_valid_q,
  output logic [8:0] out_data,
  input wire logic out_ready
);
  logic [8:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic [1:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid & in_ready_q;
  assign pop = out_ready & out_valid_q;
  assign out_data = mem_q[rd_ptr_q];

  // occupancy after this cycle's push and pop
  always_comb begin
    count_d = count_q;
    if (push & ~pop) begin
      count_d = count_q + 2'h1;
    end else if (pop & ~push) begin
      count_d = count_q - 2'h1;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_d;
      in_ready_q <= (count_d != 2'h2);
      out_valid_q <= (count_d != 2'h0);
    end
  end
endmodule
`default_nettype wire

// [core/frame_timing.sv]
// frame_timing: transmit framing, guard wait timer, receive parity and flags
// assumes same-clock register port and demodulator, async subcarrier pin
// Functional notes
// R1: symbol-one burst length from 3-bit code
// R2: burst level from separate level control input
// R3: wait starts at tx end or rx end
// R4: wait unit carrier-based or half bit
// R5: wait count eleven bits, high bits 5..3
// R6: no transmit start before wait elapsed
// R7: stop bit plus guard times, type B
// R8: wait control resets to c0
// R9: parity appended after each sent byte
// R10: rx parity checked, parity not stored
// R11: trailing symbol selected by 2-bit code
// R12: leading symbol selected by 2-bit code
// R13: frame start raises interrupt when enabled
// R14: sticky frame start flag, software clears
// R15: subcarrier raises same interrupt when enabled
// R16: sticky subcarrier flag, software clears
// R17: live subcarrier status bit read-only
// R18: partial last byte kept when allowed
// R19: multi receive appends error copy
// R20: baud code 2 26k, 3 52k
// R21: down-counter gates transmit start
// R22: reserved bits read zero, writes ignored
`timescale 1ns/10ps
`default_nettype none
module frame_timing
  import framer_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic tx_start,
  input wire logic tx_in_valid,
  input wire logic [7:0] tx_in_data,
  input wire logic tx_in_last,
  output logic tx_in_ready,
  input wire logic [11:0] half_bit_period,
  input wire logic type_b_mode,
  input wire logic burst_level_control,
  output logic tx_bit_valid_q,
  output logic tx_bit_q,
  output logic [1:0] tx_sym_q,
  output logic tx_busy_q,
  output logic tx_wait_busy_q,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_byte_parity,
  input wire logic rx_byte_partial,
  input wire logic rx_end,
  input wire logic crc_check_enable,
  input wire logic [7:0] error_copy,
  input wire logic sof_seen,
  input wire logic subcarrier_pin,
  output logic rx_out_valid_q,
  output logic [7:0] rx_out_data_q,
  output logic rx_out_is_error_q,
  output logic rx_parity_error_q,
  output logic rx_stop_q,
  output logic rx_frame_start_interrupt_q,
  output logic [2:0] rx_baud_select_q,
  output logic rx_baud_reserved_q,
  output logic disturbance_suppress_q
);
  logic [7:0] burst_length_config_q;
  logic [7:0] tx_wait_control_q;
  logic [7:0] tx_wait_low_q;
  logic [7:0] frame_control_q;
  logic [7:0] sof_ctrl_q;
  logic [7:0] rx_control_q;
  logic sof_flag_q;
  logic subc_flag_q;
  logic subc_meta_q;
  logic subc_sync_q;
  logic subc_prev_q;
  logic subc_rise;
  logic wr_sof;
  logic [10:0] guard_wait_count;
  logic [10:0] wait_cnt_q;
  logic [8:0] unit_cnt_q;
  logic unit_tick;
  logic [11:0] half_cnt_q;
  logic half_tick;
  logic phase_q;
  logic bit_tick;
  logic wait_tick;
  logic wait_load;
  logic tx_done;
  tx_state_type state_q;
  logic pend_q;
  logic start_go;
  logic [2:0] bit_idx_q;
  logic [7:0] burst_cnt_q;
  logic [2:0] guard_cnt_q;
  logic buf_valid;
  logic [8:0] buf_data;
  logic buf_pop;
  logic [1:0] lead_sel;
  logic [1:0] trail_sel;
  logic [2:0] stop_len;
  logic stop_on;
  logic err_pend_q;
  logic keep_byte;

  assign lead_sel = frame_control_q[LEAD_SYM_MSB:LEAD_SYM_LSB];
  assign trail_sel = frame_control_q[TRAIL_SYM_MSB:TRAIL_SYM_LSB];
  assign stop_len = tx_wait_control_q[STOP_LEN_MSB:STOP_LEN_LSB];
  assign stop_on = type_b_mode & (stop_len != 3'h0); // R7
  assign guard_wait_count = {tx_wait_control_q[WAIT_HIGH_MSB:WAIT_HIGH_LSB], tx_wait_low_q}; // R5
  assign wr_sof = reg_wr & (reg_addr == ADDR_SOF_DETECT);

  // register writes, writable bits only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      burst_length_config_q <= BURST_LEN_RESET;
      tx_wait_control_q <= WAIT_CTRL_RESET; // R8
      tx_wait_low_q <= WAIT_LOW_RESET;
      frame_control_q <= FRAME_CTRL_RESET;
      sof_ctrl_q <= SOF_DETECT_RESET;
      rx_control_q <= RX_CTRL_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_BURST_LEN: burst_length_config_q <= reg_wdata & BURST_LEN_WMASK; // R22
        ADDR_WAIT_CTRL: tx_wait_control_q <= reg_wdata & WAIT_CTRL_WMASK;
        ADDR_WAIT_LOW: tx_wait_low_q <= reg_wdata & WAIT_LOW_WMASK;
        ADDR_FRAME_CTRL: frame_control_q <= reg_wdata & FRAME_CTRL_WMASK; // R22
        ADDR_SOF_DETECT: sof_ctrl_q <= reg_wdata & SOF_DETECT_WMASK;
        ADDR_RX_CTRL: rx_control_q <= reg_wdata & RX_CTRL_WMASK; // R22
        default: ;
      endcase
    end
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_BURST_LEN: reg_rdata_q <= burst_length_config_q;
        ADDR_WAIT_CTRL: reg_rdata_q <= tx_wait_control_q;
        ADDR_WAIT_LOW: reg_rdata_q <= tx_wait_low_q;
        ADDR_FRAME_CTRL: reg_rdata_q <= frame_control_q;
        ADDR_SOF_DETECT: reg_rdata_q <= sof_ctrl_q | {3'h0, sof_flag_q, 2'h0, subc_flag_q,
                                                      subc_sync_q}; // R17
        ADDR_RX_CTRL: reg_rdata_q <= rx_control_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // subcarrier pin synchroniser and edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      subc_meta_q <= 1'b0;
      subc_sync_q <= 1'b0;
      subc_prev_q <= 1'b0;
    end else begin
      subc_meta_q <= subcarrier_pin;
      subc_sync_q <= subc_meta_q;
      subc_prev_q <= subc_sync_q;
    end
  end
  assign subc_rise = subc_sync_q & ~subc_prev_q;

  // sticky flags: write one clears, an event wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sof_flag_q <= 1'b0;
      subc_flag_q <= 1'b0;
    end else begin
      sof_flag_q <= sof_seen | (sof_flag_q & ~(wr_sof & reg_wdata[SOF_FLAG_BIT])); // R14
      subc_flag_q <= subc_rise | (subc_flag_q & ~(wr_sof & reg_wdata[SUBC_FLAG_BIT])); // R16
    end
  end

  // interrupt pulse from either detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_frame_start_interrupt_q <= 1'b0;
    end else begin
      rx_frame_start_interrupt_q <= (sof_seen & sof_ctrl_q[SOF_IRQ_EN_BIT]) | // R13
                                    (subc_rise & sof_ctrl_q[SUBC_IRQ_EN_BIT]); // R15
    end
  end

  // carrier wait unit divider, restarts on load
  assign unit_tick = (unit_cnt_q == WAIT_UNIT_CYCLES - 9'h001);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unit_cnt_q <= 9'h000;
    end else if (wait_load | unit_tick) begin
      unit_cnt_q <= 9'h000;
    end else begin
      unit_cnt_q <= unit_cnt_q + 9'h001;
    end
  end

  // half-bit divider; every second half tick is a bit slot
  assign half_tick = (half_cnt_q + 12'h001 >= half_bit_period);
  assign bit_tick = half_tick & phase_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_q <= 12'h000;
      phase_q <= 1'b0;
    end else if (half_tick) begin
      half_cnt_q <= 12'h000;
      phase_q <= ~phase_q;
    end else begin
      half_cnt_q <= half_cnt_q + 12'h001;
    end
  end

  // guard wait down-counter
  assign wait_load = tx_wait_control_q[WAIT_START_BIT] ? rx_end : tx_done; // R3
  assign wait_tick = tx_wait_control_q[WAIT_UNIT_BIT] ? half_tick : unit_tick; // R4
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt_q <= 11'h000;
      tx_wait_busy_q <= 1'b0;
    end else begin
      if (wait_load) begin
        wait_cnt_q <= guard_wait_count; // R21
      end else if (wait_tick && wait_cnt_q != 11'h000) begin
        wait_cnt_q <= wait_cnt_q - 11'h001; // R21
      end
      tx_wait_busy_q <= wait_load ? (guard_wait_count != 11'h000) :
                        (wait_cnt_q > 11'h001) | (wait_cnt_q == 11'h001 & ~wait_tick);
    end
  end

  word_buffer u_buf (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(tx_in_valid),
    .in_data({tx_in_last, tx_in_data}),
    .in_ready_q(tx_in_ready),
    .out_valid_q(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  // start request held until the wait allows it
  assign start_go = (state_q == ST_IDLE) & pend_q & buf_valid & (wait_cnt_q == 11'h000) &
                    ~wait_load; // R6
  assign tx_done = (state_q == ST_DONE);
  assign buf_pop = bit_tick & buf_valid &
                   (((state_q == ST_DATA) & (bit_idx_q == 3'h7) &
                     ~frame_control_q[TX_PARITY_BIT]) | (state_q == ST_PARITY));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= tx_start | (pend_q & ~start_go);
    end
  end

  // transmit sequencer: lead, data, parity, trail, stop, guard
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_idx_q <= 3'h0;
      burst_cnt_q <= 8'h00;
      guard_cnt_q <= 3'h0;
      tx_bit_valid_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_sym_q <= KIND_DATA;
      tx_busy_q <= 1'b0;
    end else begin
      tx_bit_valid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_go) begin
            tx_busy_q <= 1'b1;
            bit_idx_q <= 3'h0;
            burst_cnt_q <= burst_bits(burst_length_config_q[BURST_LEN_MSB:BURST_LEN_LSB]); // R1
            state_q <= (lead_sel == SEL_NONE) ? ST_DATA : ST_LEAD; // R12
          end
        end
        ST_LEAD, ST_TRAIL: begin
          if (bit_tick) begin
            tx_bit_valid_q <= 1'b1;
            tx_sym_q <= (state_q == ST_LEAD) ? lead_sel : trail_sel; // R11
            tx_bit_q <= 1'b0;
            if ((state_q == ST_LEAD ? lead_sel : trail_sel) == SEL_SYM1) begin
              tx_bit_q <= burst_level_control; // R2
              burst_cnt_q <= burst_cnt_q - 8'h01;
            end
            if ((state_q == ST_LEAD ? lead_sel : trail_sel) != SEL_SYM1 ||
                burst_cnt_q == 8'h01) begin
              burst_cnt_q <= burst_bits(burst_length_config_q[BURST_LEN_MSB:BURST_LEN_LSB]);
              state_q <= (state_q == ST_LEAD) ? ST_DATA : (stop_on ? ST_STOP : ST_DONE);
            end
          end
        end
        ST_DATA: begin
          if (bit_tick && buf_valid) begin
            tx_bit_valid_q <= 1'b1;
            tx_sym_q <= KIND_DATA;
            tx_bit_q <= buf_data[bit_idx_q];
            bit_idx_q <= bit_idx_q + 3'h1;
            if (bit_idx_q == 3'h7) begin
              if (frame_control_q[TX_PARITY_BIT]) begin
                state_q <= ST_PARITY; // R9
              end else if (buf_data[8]) begin
                state_q <= (trail_sel != SEL_NONE) ? ST_TRAIL : (stop_on ? ST_STOP : ST_DONE);
              end
            end
          end
        end
        ST_PARITY: begin
          if (bit_tick) begin
            tx_bit_valid_q <= 1'b1;
            tx_sym_q <= KIND_DATA;
            tx_bit_q <= ~(^buf_data[7:0]); // R9
            if (buf_data[8]) begin
              state_q <= (trail_sel != SEL_NONE) ? ST_TRAIL : (stop_on ? ST_STOP : ST_DONE);
            end else begin
              state_q <= ST_DATA;
            end
          end
        end
        ST_STOP: begin
          if (bit_tick) begin
            tx_bit_valid_q <= 1'b1;
            tx_sym_q <= KIND_DATA;
            tx_bit_q <= 1'b1;
            guard_cnt_q <= stop_len - 3'h1;
            state_q <= (stop_len == 3'h1) ? ST_DONE : ST_GUARD; // R7
          end
        end
        ST_GUARD: begin
          if (bit_tick) begin
            tx_bit_valid_q <= 1'b1;
            tx_sym_q <= KIND_DATA;
            tx_bit_q <= 1'b1;
            guard_cnt_q <= guard_cnt_q - 3'h1;
            if (guard_cnt_q == 3'h1) begin
              state_q <= ST_DONE; // R7
            end
          end
        end
        ST_DONE: begin
          tx_busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // receive path: parity check, partial bytes, error copy, stop
  assign keep_byte = ~rx_byte_partial | ~crc_check_enable | rx_control_q[ALLOW_BITS_BIT]; // R18
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_out_valid_q <= 1'b0;
      rx_out_data_q <= 8'h00;
      rx_out_is_error_q <= 1'b0;
      rx_parity_error_q <= 1'b0;
      rx_stop_q <= 1'b0;
      err_pend_q <= 1'b0;
    end else begin
      rx_out_valid_q <= 1'b0;
      rx_out_is_error_q <= 1'b0;
      rx_parity_error_q <= 1'b0;
      rx_stop_q <= rx_end & ~rx_control_q[MULTI_RX_BIT]; // R19
      if (rx_byte_valid && keep_byte) begin
        rx_out_valid_q <= 1'b1;
        rx_out_data_q <= rx_byte_data; // R10
        rx_parity_error_q <= rx_control_q[RX_PARITY_BIT] &
                             ~(rx_byte_partial | (^{rx_byte_data, rx_byte_parity})); // R10
        err_pend_q <= err_pend_q | (rx_end & rx_control_q[MULTI_RX_BIT]);
      end else if (err_pend_q || (rx_end && rx_control_q[MULTI_RX_BIT])) begin
        rx_out_valid_q <= 1'b1;
        rx_out_data_q <= error_copy; // R19
        rx_out_is_error_q <= 1'b1;
        err_pend_q <= 1'b0;
      end
    end
  end

  // decoded receive configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_baud_select_q <= 3'h0;
      rx_baud_reserved_q <= 1'b1;
      disturbance_suppress_q <= 1'b0;
    end else begin
      rx_baud_select_q <= rx_control_q[BAUD_MSB:BAUD_LSB];
      rx_baud_reserved_q <= (rx_control_q[BAUD_MSB:BAUD_LSB] != BAUD_26K) &&
                            (rx_control_q[BAUD_MSB:BAUD_LSB] != BAUD_52K); // R20
      disturbance_suppress_q <= rx_control_q[DISTURB_BIT];
    end
  end
endmodule
`default_nettype wire

// [dv/frame_timing_chk.sv]
// frame_timing_chk: port-level assertions
// assumes one clk domain and an async low reset
`timescale 1ns/10ps
`default_nettype none
module frame_timing_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata_q,
  input wire logic tx_bit_valid_q,
  input wire logic tx_bit_q,
  input wire logic [1:0] tx_sym_q,
  input wire logic burst_level_control,
  input wire logic tx_busy_q,
  input wire logic tx_wait_busy_q,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_byte_partial,
  input wire logic rx_end,
  input wire logic [7:0] error_copy,
  input wire logic sof_seen,
  input wire logic subcarrier_pin,
  input wire logic rx_out_valid_q,
  input wire logic [7:0] rx_out_data_q,
  input wire logic rx_out_is_error_q,
  input wire logic rx_stop_q,
  input wire logic rx_frame_start_interrupt_q,
  input wire logic [2:0] rx_baud_select_q,
  input wire logic rx_baud_reserved_q
);
  // checks are off in reset
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  burst_level_a: assert property (tx_bit_valid_q && tx_sym_q == 2'h2 |->
    tx_bit_q == burst_level_control) else $error("burst bit at wrong level");
  wait_gate_a: assert property ($rose(tx_busy_q) |-> !$past(tx_wait_busy_q))
    else $error("start inside guard wait");
  rx_copy_a: assert property (rx_byte_valid && !rx_byte_partial |=>
    rx_out_valid_q && rx_out_data_q == $past(rx_byte_data)) else $error("rx byte lost");
  err_word_a: assert property (rx_out_is_error_q |->
    rx_out_valid_q && rx_out_data_q == $past(error_copy)) else $error("bad error word");
  stop_cause_a: assert property (rx_stop_q |-> $past(rx_end))
    else $error("stop without stream end");
  irq_cause_a: assert property (rx_frame_start_interrupt_q |-> $past(sof_seen)
    || $past(subcarrier_pin, 2) || $past(subcarrier_pin, 3)) else $error("irq without cause");
  rd_unmapped_a: assert property (reg_rd && (reg_addr < 8'h30 || reg_addr > 8'h35)
    |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  baud_flag_a: assert property (rx_baud_reserved_q ==
    !(rx_baud_select_q inside {3'h2, 3'h3})) else $error("baud reserved flag wrong");
  cover property (rx_out_is_error_q);
  cover property (rx_frame_start_interrupt_q);
  cover property ($fell(tx_wait_busy_q));
endmodule
bind frame_timing frame_timing_chk i_chk (.*);
`default_nettype wire

// [dv/tag_model.sv]
// tag_model: far-side tag, records bit slots, sends bytes
// assumes the reader's clk; subcarrier idles low
`timescale 1ns/10ps
`default_nettype none
module tag_model (
  input wire logic clk,
  input wire logic bit_valid,
  input wire logic bit_val,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_parity,
  output logic byte_partial,
  output logic stream_end,
  output logic sof,
  output logic subc
);
  int nbits = 0;
  logic [63:0] bits = '0;
  // quiet field at time zero
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    byte_parity = 1'b0;
    byte_partial = 1'b0;
    stream_end = 1'b0;
    sof = 1'b0;
    subc = 1'b0;
  end
  // record every bit slot in send order
  always @(posedge clk) begin
    if (bit_valid === 1'b1) begin
      bits[nbits] <= bit_val;
      nbits <= nbits + 1;
    end
  end
  // one byte, one-cycle pulse
  task automatic send(input logic [7:0] d, input logic p, part);
    @(posedge clk);
    byte_valid <= 1'b1;
    byte_data <= d;
    byte_parity <= p;
    byte_partial <= part;
    @(posedge clk);
    byte_valid <= 1'b0;
    byte_data <= ~d;
  endtask
  // frame start or stream end pulse
  task automatic mark(input logic is_sof);
    @(posedge clk);
    sof <= is_sof;
    stream_end <= !is_sof;
    @(posedge clk);
    sof <= 1'b0;
    stream_end <= 1'b0;
  endtask
  task automatic set_subc(input logic v);
    @(posedge clk);
    subc <= v;
  endtask
endmodule
`default_nettype wire

// [dv/frame_timing_test.sv]
// frame_timing_test: registers, frames, guard wait, receive side
// assumes tag_model on the radio side
`timescale 1ns/10ps
`default_nettype none
module frame_timing_test
  import framer_pkg::*;
;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, tx_start = 0, tx_in_valid = 0;
  logic tx_in_last = 0, type_b_mode = 0, burst_level_control = 1, crc_check_enable = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, tx_in_data = 8'h00, error_copy = 8'h3c;
  logic [11:0] half_bit_period = 12'h002;
  wire [7:0] reg_rdata_q, rx_out_data_q, rx_byte_data;
  wire [1:0] tx_sym_q;
  wire [2:0] rx_baud_select_q;
  wire tx_in_ready, tx_bit_valid_q, tx_bit_q, tx_busy_q, tx_wait_busy_q;
  wire rx_out_valid_q, rx_out_is_error_q, rx_parity_error_q, rx_stop_q;
  wire rx_frame_start_interrupt_q, rx_baud_reserved_q, disturbance_suppress_q;
  wire rx_byte_valid, rx_byte_parity, rx_byte_partial, rx_end, sof_seen, subcarrier_pin;
  int err_total = 0, n_tests = 0, n_irq = 0;
  logic [7:0] rst_v [6] = '{8'h00, 8'hc0, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk_v [6] = '{8'h70, 8'hff, 8'hff, 8'hcf, 8'h24, 8'hcf};
  frame_timing i_dut (.*);
  tag_model i_tag (.clk(clk), .bit_valid(tx_bit_valid_q), .bit_val(tx_bit_q),
    .byte_valid(rx_byte_valid), .byte_data(rx_byte_data), .byte_parity(rx_byte_parity),
    .byte_partial(rx_byte_partial), .stream_end(rx_end), .sof(sof_seen),
    .subc(subcarrier_pin));
  // 250 MHz clock and interrupt pulse count
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_frame_start_interrupt_q === 1'b1) n_irq <= n_irq + 1;
  end
  task automatic check(input string nm, input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("reg", reg_rdata_q, exp);
  endtask
  // one-byte frame; check slots, bit values, wait
  task automatic frame(input logic [63:0] e, m, input int n, w);
    int k;
    i_tag.nbits = 0;
    i_tag.bits = '0;
    @(posedge clk);
    tx_start <= 1'b1;
    tx_in_valid <= 1'b1;
    tx_in_data <= 8'h5a;
    tx_in_last <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    tx_in_valid <= 1'b0;
    for (k = 0; k < 1000 && tx_wait_busy_q !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("slots", i_tag.nbits, n);
    check("bits", i_tag.bits & m, e);
    for (k = 0; k < 2000 && tx_wait_busy_q === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("wait", k >= w - 2 && k <= w + 2, 1'b1);
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // watchdog, well past the test length
  initial begin
    #100000;
    err_total++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd(8'h30 + i[7:0], rst_v[i]);
      wr(8'h30 + i[7:0], 8'hff);
      rd(8'h30 + i[7:0], msk_v[i]);
    end
    wr(8'h36, 8'hff);
    rd(8'h36, 8'h00);
    @(posedge clk);
    type_b_mode <= 1'b1;
    wr(ADDR_BURST_LEN, 8'h40);
    wr(ADDR_FRAME_CTRL, 8'h86);
    wr(ADDR_WAIT_CTRL, 8'h4b);
    wr(ADDR_WAIT_LOW, 8'h04);
    frame(64'h1d5a_ffff_ffff_ffff, 64'h1dff_ffff_ffff_ffff, 61, 520);
    wr(ADDR_FRAME_CTRL, 8'h00);
    wr(ADDR_WAIT_CTRL, 8'h00);
    wr(ADDR_WAIT_LOW, 8'h02);
    frame(64'h5a, 64'hff, 8, 588);
    wr(ADDR_FRAME_CTRL, 8'h40);
    wr(ADDR_RX_CTRL, 8'h40);
    crc_check_enable <= 1'b1;
    i_tag.send(8'h5a, 1'b1, 1'b0);
    #1;
    check("rx", {rx_out_valid_q, rx_out_data_q, rx_parity_error_q}, 10'h2b4);
    i_tag.send(8'h5a, 1'b0, 1'b0);
    #1;
    check("rx", {rx_out_valid_q, rx_out_data_q, rx_parity_error_q}, 10'h2b5);
    i_tag.send(8'h33, 1'b0, 1'b1);
    #1;
    check("partial", rx_out_valid_q, 1'b0);
    wr(ADDR_RX_CTRL, 8'hc0);
    i_tag.send(8'h33, 1'b0, 1'b1);
    #1;
    check("partial", {rx_out_valid_q, rx_out_data_q}, 9'h133);
    i_tag.mark(1'b0);
    #1;
    check("err", {rx_out_valid_q, rx_out_is_error_q, rx_stop_q, rx_out_data_q}, 11'h63c);
    wr(ADDR_RX_CTRL, 8'h80);
    wr(ADDR_WAIT_CTRL, 8'h80);
    i_tag.mark(1'b0);
    #1;
    check("stop", rx_stop_q, 1'b1);
    check("rx wait", tx_wait_busy_q, 1'b1);
    wr(ADDR_SOF_DETECT, 8'h24);
    i_tag.mark(1'b1);
    #1;
    check("irq", rx_frame_start_interrupt_q, 1'b1);
    rd(ADDR_SOF_DETECT, 8'h34);
    i_tag.set_subc(1'b1);
    repeat (5) @(posedge clk);
    rd(ADDR_SOF_DETECT, 8'h37);
    check("irqs", n_irq, 2);
    wr(ADDR_SOF_DETECT, 8'h36);
    rd(ADDR_SOF_DETECT, 8'h25);
    i_tag.set_subc(1'b0);
    repeat (5) @(posedge clk);
    rd(ADDR_SOF_DETECT, 8'h24);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_RX_CTRL, {4'h0, c[0], c[2:0]});
      @(posedge clk);
      #1;
      check("baud", {rx_baud_select_q, rx_baud_reserved_q, disturbance_suppress_q},
            {c[2:0], c != 2 && c != 3, c[0]});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
